/* File: hw/uem_pkg.sv */
// Package for the uncorrectable-error mask register bank.
// Assumes one core clock and a configuration-space access port.
package uem_pkg;

  localparam logic [11:0] UEM_OFFSET = 12'h108;
  localparam logic [11:0] UES_OFFSET = 12'h104;
  localparam logic [31:0] UEM_RESET = 32'h00000000;
  localparam logic [31:0] UES_RESET = 32'h00000000;
  // Writable sticky mask positions: 0, 4, 5, 12, 13, 16..20
  localparam logic [31:0] UEM_WR_MASK = 32'h001f3031;
  // Status positions that hardware can set (bit 0 is obsolete, never set)
  localparam logic [31:0] UES_EVT_MASK = 32'h001f3030;
  localparam int BIT_UNDEF = 0;
  localparam int BIT_LINK_PROTO = 4;
  localparam int BIT_SURPRISE_DOWN = 5;
  localparam int BIT_POISONED = 12;
  localparam int BIT_FLOW_CREDIT = 13;
  localparam int BIT_COMPL_TIMEOUT = 14;
  localparam int BIT_COMPL_ABORT = 15;
  localparam int BIT_UR = 20;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } cfg_req_type;

  typedef struct packed {
    logic [31:0] mask_q;
    logic [31:0] status_q;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic [31:0] log_en_q;
    logic [31:0] report_en_q;
  } state_type;

endpackage : uem_pkg

/* File: hw/uncorrectable_error_mask.sv */
// Uncorrectable-error mask and status bank for one switch port.
// Assumes config accesses are single-cycle strobes on CLK; the sticky clear
// comes from a fundamental reset only, link or hot resets do not touch it.
// Operation
// RULE1: A mask bit set to one masks the status bit at that position.
// RULE2: Masked errors are not logged in the capability logging state.
// RULE3: Masked errors are not reported toward the root complex.
// RULE4: Writable sticky mask bits 4, 5, 12, 13.
// RULE5: Writable sticky mask bits 16 through 20.
// RULE6: Bit 14 completion timeout reads zero, read-only.
// RULE7: Bit 15 completer abort reads zero, read-only.
// RULE8: Bit 0 is a plain read/write sticky bit, reset zero, no effect.
// RULE9: Status bits set on detection, sticky, cleared by writing one.
// RULE10: Mask resets to zero; sticky bits clear only on fundamental reset.
// RULE11: Reserved bits 3:1, 11:6, 31:21 read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module uncorrectable_error_mask
  import uem_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic FUND_RST,
  input wire uem_pkg::cfg_req_type CFG_REQ,
  input wire logic [31:0] ERR_DETECT,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RVALID,
  output logic [31:0] ERR_LOG_EN,
  output logic [31:0] ERR_REPORT_EN
);
  import uem_pkg::*;

  state_type s_q;
  state_type s_d;

  function automatic logic [31:0] byte_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : byte_mask

  // Events that pass the mask; bit 0 and the hardwired positions never pass
  function automatic logic [31:0] open_events(input logic [31:0] det, input logic [31:0] mask);
    return det & ~mask & UES_EVT_MASK;
  endfunction : open_events

  logic [31:0] wbits;
  logic mask_hit;
  logic stat_hit;
  logic [31:0] detect;
  assign wbits = CFG_REQ.wdata & byte_mask(CFG_REQ.be);
  assign mask_hit = CFG_REQ.addr == UEM_OFFSET;
  assign stat_hit = CFG_REQ.addr == UES_OFFSET;
  assign detect = ERR_DETECT & UES_EVT_MASK;

  always_comb
  begin
    s_d = s_q;
    s_d.rvalid_q = CFG_REQ.rd;
    s_d.rdata_q = '0;
    if (CFG_REQ.wr && mask_hit)
    begin
      // Only writable positions change; 14, 15 and reserved stay zero
      s_d.mask_q = (s_q.mask_q & ~(UEM_WR_MASK & byte_mask(CFG_REQ.be)))
                 | (wbits & UEM_WR_MASK); // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE11]
    end
    // Set wins over a same-cycle write-one clear
    s_d.status_q = s_q.status_q;
    if (CFG_REQ.wr && stat_hit)
    begin
      s_d.status_q = s_q.status_q & ~wbits; // [RULE9]
    end
    // A masked event leaves status untouched, so it is never logged
    s_d.status_q = (s_d.status_q | open_events(detect, s_q.mask_q))
                 & UES_EVT_MASK; // [RULE1] [RULE2] [RULE9]
    if (CFG_REQ.rd)
    begin
      if (mask_hit)
        s_d.rdata_q = s_q.mask_q;
      else if (stat_hit)
        s_d.rdata_q = s_q.status_q;
    end
    // Bit 0 stays out of both enables: obsolete position, no effect
    s_d.log_en_q = open_events(detect, s_q.mask_q); // [RULE2] [RULE8]
    s_d.report_en_q = open_events(detect, s_q.mask_q); // [RULE3]
    // Hot or link reset: sticky mask and status hold, strobes and pulses drop
    if (SYS_RST)
    begin
      s_d.mask_q = s_q.mask_q; // [RULE10]
      s_d.status_q = s_q.status_q; // [RULE10]
      s_d.rdata_q = '0;
      s_d.rvalid_q = 1'b0;
      s_d.log_en_q = '0;
      s_d.report_en_q = '0;
    end
  end

  // Only a fundamental reset reaches the sticky state
  always_ff @(posedge CLK)
  begin
    if (FUND_RST)
    begin
      s_q <= '{mask_q: UEM_RESET, status_q: UES_RESET, default: '0}; // [RULE10]
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign CFG_RDATA = s_q.rdata_q;
  assign CFG_RVALID = s_q.rvalid_q;
  assign ERR_LOG_EN = s_q.log_en_q;
  assign ERR_REPORT_EN = s_q.report_en_q;

  // Gating of the enables and of status by the mask
  a_masked_no_report: assert property ( // [RULE3]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (ERR_DETECT[BIT_LINK_PROTO] && s_q.mask_q[BIT_LINK_PROTO])
    |=> !ERR_REPORT_EN[BIT_LINK_PROTO])
    else $error("masked error was reported");
  a_unmasked_report: assert property ( // [RULE1]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (ERR_DETECT[BIT_UR] && !s_q.mask_q[BIT_UR]) |=> ERR_REPORT_EN[BIT_UR])
    else $error("unmasked error not reported");
  a_masked_no_log: assert property ( // [RULE2]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (ERR_DETECT[BIT_POISONED] && s_q.mask_q[BIT_POISONED] && !s_q.status_q[BIT_POISONED])
    |=> !s_q.status_q[BIT_POISONED] && !ERR_LOG_EN[BIT_POISONED])
    else $error("masked error was logged");

  // Hardwired and reserved positions; state is unknown before the first reset edge
  a_timeout_zero: assert property ( // [RULE6]
    @(posedge CLK) disable iff (FUND_RST)
    !s_q.mask_q[BIT_COMPL_TIMEOUT])
    else $error("timeout mask bit not zero");
  a_abort_zero: assert property ( // [RULE7]
    @(posedge CLK) disable iff (FUND_RST)
    !s_q.mask_q[BIT_COMPL_ABORT])
    else $error("abort mask bit not zero");
  a_reserved_zero: assert property ( // [RULE11]
    @(posedge CLK) disable iff (FUND_RST)
    (s_q.mask_q & ~UEM_WR_MASK) == '0)
    else $error("reserved mask bit set");

  // Mask writes, lane by lane
  a_mask_write_lands: assert property ( // [RULE5]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (CFG_REQ.wr && mask_hit && CFG_REQ.be[2])
    |=> s_q.mask_q[BIT_UR] == $past(CFG_REQ.wdata[BIT_UR]))
    else $error("mask write not stored");
  a_flow_bit_write: assert property ( // [RULE4]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (CFG_REQ.wr && mask_hit && CFG_REQ.be[1])
    |=> s_q.mask_q[BIT_FLOW_CREDIT] == $past(CFG_REQ.wdata[BIT_FLOW_CREDIT]))
    else $error("flow credit mask not stored");
  a_undef_stored: assert property ( // [RULE8]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (CFG_REQ.wr && mask_hit && CFG_REQ.be[0])
    |=> s_q.mask_q[BIT_UNDEF] == $past(CFG_REQ.wdata[BIT_UNDEF]))
    else $error("obsolete mask bit not stored");
  a_lane_kept: assert property ( // [RULE5]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (CFG_REQ.wr && mask_hit && !CFG_REQ.be[2]) |=> $stable(s_q.mask_q[23:16]))
    else $error("disabled byte lane changed");
  a_undef_no_effect: assert property ( // [RULE8]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    ##1 !ERR_REPORT_EN[BIT_UNDEF] && !s_q.status_q[BIT_UNDEF])
    else $error("obsolete bit has effect");

  // Status set and clear; a set in the same cycle as a clear wins
  a_status_sets: assert property ( // [RULE9]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (ERR_DETECT[BIT_SURPRISE_DOWN] && !s_q.mask_q[BIT_SURPRISE_DOWN])
    |=> s_q.status_q[BIT_SURPRISE_DOWN])
    else $error("unmasked event did not set status");
  a_set_wins: assert property ( // [RULE9]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (CFG_REQ.wr && stat_hit && CFG_REQ.be[0] && CFG_REQ.wdata[BIT_LINK_PROTO]
      && ERR_DETECT[BIT_LINK_PROTO] && !s_q.mask_q[BIT_LINK_PROTO])
    |=> s_q.status_q[BIT_LINK_PROTO])
    else $error("clear beat a same-cycle set");
  a_clear_lands: assert property ( // [RULE9]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (CFG_REQ.wr && stat_hit && CFG_REQ.be[2] && CFG_REQ.wdata[BIT_UR] && !ERR_DETECT[BIT_UR])
    |=> !s_q.status_q[BIT_UR])
    else $error("write-one did not clear status");

  // Reads answer one cycle later with the value before any same-cycle write
  a_read_mask: assert property ( // [RULE4] [RULE5]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (CFG_REQ.rd && mask_hit) |=> CFG_RVALID && CFG_RDATA == $past(s_q.mask_q))
    else $error("mask read wrong");
  a_unmapped_zero: assert property ( // [RULE11]
    @(posedge CLK) disable iff (SYS_RST || FUND_RST)
    (CFG_REQ.rd && !mask_hit && !stat_hit) |=> CFG_RVALID && CFG_RDATA == '0)
    else $error("unmapped read not zero");

  // Reset behaviour
  a_status_sticky: assert property ( // [RULE9]
    @(posedge CLK) disable iff (FUND_RST)
    (SYS_RST && s_q.status_q[BIT_SURPRISE_DOWN]) |=> s_q.status_q[BIT_SURPRISE_DOWN])
    else $error("status lost on hot reset");
  a_mask_sticky: assert property ( // [RULE10]
    @(posedge CLK) disable iff (FUND_RST)
    SYS_RST |=> $stable(s_q.mask_q))
    else $error("mask lost on hot reset");
  a_hot_quiet: assert property ( // [RULE10]
    @(posedge CLK) disable iff (FUND_RST)
    SYS_RST |=> !CFG_RVALID && ERR_LOG_EN == '0 && ERR_REPORT_EN == '0)
    else $error("outputs active after hot reset");
  a_fund_clears: assert property ( // [RULE10]
    @(posedge CLK)
    FUND_RST |=> s_q.mask_q == UEM_RESET && s_q.status_q == UES_RESET)
    else $error("fundamental reset did not clear");

  // One set of checks per bit position, chosen by what the position holds
  genvar b;
  generate
    for (b = 0; b < 32; b++)
    begin : g_bit
      if (UEM_WR_MASK[b] && UES_EVT_MASK[b])
      begin : g_event
        a_gated_bit: assert property ( // [RULE1] [RULE2] [RULE3]
          @(posedge CLK) disable iff (SYS_RST || FUND_RST)
          (ERR_DETECT[b] && s_q.mask_q[b] && !s_q.status_q[b])
          |=> !s_q.status_q[b] && !ERR_LOG_EN[b] && !ERR_REPORT_EN[b])
          else $error("masked event passed");
        a_open_bit: assert property ( // [RULE1] [RULE9]
          @(posedge CLK) disable iff (SYS_RST || FUND_RST)
          (ERR_DETECT[b] && !s_q.mask_q[b])
          |=> s_q.status_q[b] && ERR_LOG_EN[b] && ERR_REPORT_EN[b])
          else $error("open event not passed");
      end
      else if (UEM_WR_MASK[b])
      begin : g_undef
        a_undef_quiet: assert property ( // [RULE8]
          @(posedge CLK) disable iff (FUND_RST)
          !s_q.status_q[b] && !ERR_LOG_EN[b] && !ERR_REPORT_EN[b])
          else $error("obsolete position has effect");
      end
      else
      begin : g_fixed
        a_fixed_zero: assert property ( // [RULE6] [RULE7] [RULE11]
          @(posedge CLK) disable iff (FUND_RST)
          !s_q.mask_q[b] && !s_q.status_q[b] && !ERR_LOG_EN[b] && !ERR_REPORT_EN[b])
          else $error("hardwired position not zero");
      end
    end
  endgenerate

endmodule : uncorrectable_error_mask
`default_nettype wire

/* File: tb/rc_model.sv */
// Root complex stand-in: counts error reports that reach it.
// Assumes report enables are one-cycle pulses on CLK.
`timescale 1ns/1ps
`default_nettype none
module rc_model
(
  input wire logic CLK,
  input wire logic [31:0] REPORT,
  output var int reports
);
  always @(posedge CLK)
    reports <= reports + $countones(REPORT);
endmodule : rc_model
`default_nettype wire

/* File: tb/test_uncorrectable_error_mask.sv */
// Self-checking bench for the uncorrectable-error mask bank.
// Assumes one-cycle config strobes and the root complex stand-in.
`timescale 1ns/1ps
`default_nettype none
module test_uncorrectable_error_mask;
  import uem_pkg::*;
  logic clk = 0, sys_rst = 1, fund_rst = 1, rvalid;
  cfg_req_type req = '0;
  logic [3:0] lanes = 4'hf;
  logic [31:0] det = '0, rdata, log_en, rep_en, m, d, mx;
  int failures = 0, samples_checked = 0, seen, want = 0;
  always #4 clk = ~clk;
  uncorrectable_error_mask dut (.CLK(clk), .SYS_RST(sys_rst), .FUND_RST(fund_rst),
    .CFG_REQ(req), .ERR_DETECT(det), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
    .ERR_LOG_EN(log_en), .ERR_REPORT_EN(rep_en));
  rc_model rc (.CLK(clk), .REPORT(rep_en), .reports(seen));
  function automatic logic [31:0] hit_exp(logic [31:0] dv, logic [31:0] mv);
    return dv & ~mv & UES_EVT_MASK;
  endfunction : hit_exp
  task automatic close_out();
    $display("Checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Reads wait on the valid pulse under a bound; a hang ends the run
  task automatic cfg(logic w, logic [11:0] a, logic [31:0] v, logic [31:0] e);
    int i;
    @(posedge clk);
    req <= '{rd: !w, wr: w, addr: a, wdata: v, be: lanes};
    @(posedge clk);
    req <= '0;
    if (!w)
    begin
      #1;
      for (i = 0; i < 4 && rvalid !== 1'b1; i++)
        @(posedge clk) #1;
      chk("read valid", 32'h1, {31'h0, rvalid});
      if (rvalid !== 1'b1)
        close_out();
      chk("read data", e, rdata);
    end
  endtask : cfg
  task automatic hit(logic [31:0] dv, logic [31:0] mv);
    @(posedge clk);
    det <= dv;
    @(posedge clk);
    det <= '0;
    #1;
    chk("log enable", hit_exp(dv, mv), log_en);
    chk("report enable", hit_exp(dv, mv), rep_en);
    want += $countones(hit_exp(dv, mv));
  endtask : hit
  initial
  begin
    int i;
    void'($urandom(32'h1ad6));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    fund_rst <= 1'b0;
    cfg(1'b0, UEM_OFFSET, '0, UEM_RESET);
    cfg(1'b0, UES_OFFSET, '0, UES_RESET);
    cfg(1'b1, 12'h10c, '1, '0);
    cfg(1'b0, 12'h10c, '0, '0);
    for (i = 0; i < 10; i++)
    begin
      m = (i == 0) ? '1 : (i == 1) ? '0 : $urandom;
      // Random detects also strike the hardwired and obsolete positions
      d = (i < 2) ? UES_EVT_MASK : $urandom;
      mx = m & UEM_WR_MASK;
      cfg(1'b1, UEM_OFFSET, m, '0);
      cfg(1'b0, UEM_OFFSET, '0, mx);
      cfg(1'b1, UES_OFFSET, '1, '0);
      hit(d, m);
      cfg(1'b0, UES_OFFSET, '0, hit_exp(d, m));
    end
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    cfg(1'b0, UEM_OFFSET, '0, mx);
    cfg(1'b0, UES_OFFSET, '0, hit_exp(d, m));
    @(posedge clk);
    fund_rst <= 1'b1;
    @(posedge clk);
    fund_rst <= 1'b0;
    cfg(1'b0, UEM_OFFSET, '0, UEM_RESET);
    cfg(1'b0, UES_OFFSET, '0, UES_RESET);
    // A detect that meets a write-one clear in the same cycle must stay set
    @(posedge clk);
    det <= UES_EVT_MASK;
    req <= '{rd: 1'b0, wr: 1'b1, addr: UES_OFFSET, wdata: '1, be: 4'hf};
    @(posedge clk);
    det <= '0;
    req <= '0;
    want += $countones(UES_EVT_MASK);
    cfg(1'b0, UES_OFFSET, '0, UES_EVT_MASK);
    // Lanes whose enable is low keep their old bits
    cfg(1'b1, UEM_OFFSET, '1, '0);
    lanes = 4'h4;
    cfg(1'b1, UEM_OFFSET, '0, '0);
    lanes = 4'hf;
    cfg(1'b0, UEM_OFFSET, '0, UEM_WR_MASK & 32'hff00ffff);
    chk("reports", want, seen);
    close_out();
  end
endmodule : test_uncorrectable_error_mask
`default_nettype wire
